// ==== logic/fr_unary_alu.sv ====
// execution datapath for single-operand file-register instructions
`timescale 1ns/1ps
// What this block does
// - The invert op writes the bitwise inverse of the file register and updates zero.
// - Destination bit low sends the result to the working register, high to the file reg.
// - Clearing the file register writes zero there and always sets the zero flag.
// - Clearing the working register loads zero into it and always sets the zero flag.
// - Plain decrement subtracts one, writes the destination and updates zero.
// - Decrement-and-skip subtracts one and writes the destination with flags unchanged.
// - A zero decrement-and-skip result turns the next instruction into an idle slot.
// - Increment-and-skip adds one and writes the destination with flags unchanged.
// - A zero increment-and-skip result, wrap included, turns the next slot idle.
module fr_unary_alu
  import fr_unary_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [OP_W-1:0] op,
  input wire logic dest,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic [DATA_W-1:0] file_rdata,
  output logic file_we,
  output logic [ADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] work_reg,
  output logic zero_flag,
  output logic idle_slot,
  output logic busy_skip
);
  // ************************************************************
  // operation decode
  // ************************************************************
  logic [DATA_W-1:0] result;
  logic zero;
  logic flag_we;
  logic skip;
  logic legal;
  logic exec;
  logic to_file;
  logic to_work;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [DATA_W-1:0] work_ff;
  logic zero_ff;
  logic fwe_ff;
  logic [ADDR_W-1:0] faddr_ff;
  logic [DATA_W-1:0] fdata_ff;
  logic idle_ff;

  fr_unary_calc u_calc (
    .op(op),
    .operand(file_rdata),
    .result(result),
    .zero(zero),
    .flag_we(flag_we),
    .skip(skip),
    .legal(legal)
  );

  // the slot after a taken skip is discarded, so its issue is ignored
  assign exec = issue && legal && (state_ff == ST_RUN);
  // destination routing; clear ops have fixed targets
  assign to_file = exec && (op != OP_ZERO_WORK) && ((op == OP_ZERO_FILE) || (dest == DEST_FILE));
  assign to_work = exec && (op != OP_ZERO_FILE) && ((op == OP_ZERO_WORK) || (dest == DEST_WORK));

  // ************************************************************
  // skip sequencer
  // ************************************************************
  always_comb begin
    nxt_state = ST_RUN;
    case (state_ff)
      // zero result of a skip op schedules a discarded slot
      ST_RUN: begin
        nxt_state = (exec && skip) ? ST_SKIP : ST_RUN;
      end
      ST_SKIP: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_ff <= 1'b0;
    end else begin
      // idle slot marker during the discarded cycle
      idle_ff <= (nxt_state == ST_SKIP);
    end
  end

  // ************************************************************
  // destination and flag registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      work_ff <= W_RESET;
    end else if (to_work) begin
      // result visible the cycle after issue
      work_ff <= result;
    end
  end

  // skip forms keep the flag, so a test pending on it survives a loop count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zero_ff <= 1'b0;
    end else if (exec && flag_we) begin
      // zero flag follows result; clears yield one
      zero_ff <= zero;
    end
  end

  // registered write port gives the file a clean one-cycle strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fwe_ff <= 1'b0;
      faddr_ff <= ADDR_RESET;
      fdata_ff <= ZERO_BYTE;
    end else begin
      fwe_ff <= to_file;
      if (to_file) begin
        faddr_ff <= file_addr;
        fdata_ff <= result;
      end
    end
  end

  assign file_we = fwe_ff;
  assign file_waddr = faddr_ff;
  assign file_wdata = fdata_ff;
  assign work_reg = work_ff;
  assign zero_flag = zero_ff;
  assign idle_slot = idle_ff;
  // fetch may hold on busy_skip; it equals idle_slot, so either can be used
  assign busy_skip = (state_ff == ST_SKIP);

  // ************************************************************
  // checks
  // ************************************************************
  a_invert_value: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_INVERT && dest == DEST_WORK) |=> work_reg == ~$past(file_rdata))
    else $error("invert result wrong");
  a_dest_file: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_DEC && dest == DEST_FILE) |=> file_we && $stable(work_reg))
    else $error("file destination not written");
  a_zero_file_reg_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_ZERO_FILE) |=> file_we && file_wdata == ZERO_BYTE && zero_flag)
    else $error("clear file wrong");
  a_zero_work_reg_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_ZERO_WORK) |=> !file_we && work_reg == ZERO_BYTE && zero_flag)
    else $error("clear work wrong");
  a_dec_value: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_DEC && dest == DEST_WORK) |=>
      work_reg == $past(file_rdata) - ONE_BYTE && zero_flag == (work_reg == ZERO_BYTE))
    else $error("decrement wrong");
  a_skip_flags: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && (op == OP_DEC_SKIP || op == OP_INC_SKIP)) |=> $stable(zero_flag))
    else $error("skip op changed flag");
  a_dec_skip: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_DEC_SKIP) |=>
      (idle_slot == ($past(file_rdata) == ONE_BYTE)) ##1 !idle_slot || !$past(idle_slot))
    else $error("decrement skip wrong");
  a_inc_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_INC_SKIP && file_rdata == ~ZERO_BYTE) |=> idle_slot && busy_skip)
    else $error("increment wrap skip missing");
  a_inc_value: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_INC_SKIP && dest == DEST_FILE) |=>
      file_wdata == $past(file_rdata) + ONE_BYTE && file_waddr == $past(file_addr))
    else $error("increment result wrong");
  a_no_skip: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && !skip) |=> !busy_skip)
    else $error("non-skip op took two cycles");

  // ************************************************************
  // checks on destinations and refused slots
  // ************************************************************
  // a discarded slot must leave every visible result alone
  a_refuse_slot: assert property (@(posedge clock) disable iff (!rst_n)
    (busy_skip && issue) |=> !file_we && !idle_slot && $stable(work_reg) && $stable(zero_flag))
    else $error("discarded slot executed");
  a_invert_file: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_INVERT && dest == DEST_FILE) |=>
      file_we && file_wdata == ~$past(file_rdata) && zero_flag == (file_wdata == ZERO_BYTE))
    else $error("invert to file wrong");
  a_dec_file: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_DEC && dest == DEST_FILE) |=>
      file_wdata == $past(file_rdata) - ONE_BYTE && zero_flag == (file_wdata == ZERO_BYTE))
    else $error("decrement to file wrong");
  a_dest_work: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && dest == DEST_WORK && op != OP_ZERO_FILE) |=> !file_we)
    else $error("work destination wrote the file");
  a_inc_work: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_INC_SKIP && dest == DEST_WORK) |=>
      work_reg == $past(file_rdata) + ONE_BYTE && idle_slot == (work_reg == ZERO_BYTE))
    else $error("increment to work wrong");
  a_idle_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    idle_slot |=> !idle_slot && !busy_skip)
    else $error("idle slot longer than one cycle");
  a_addr_follow: assert property (@(posedge clock) disable iff (!rst_n)
    to_file |=> file_we && file_waddr == $past(file_addr))
    else $error("write address lost");
  a_illegal_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (issue && !legal) |=> !file_we && $stable(work_reg) && $stable(zero_flag))
    else $error("illegal op had an effect");
  a_dec_skip_file: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_DEC_SKIP && dest == DEST_FILE) |=>
      file_we && file_wdata == $past(file_rdata) - ONE_BYTE)
    else $error("decrement skip to file wrong");
  a_dec_skip_work: assert property (@(posedge clock) disable iff (!rst_n)
    (exec && op == OP_DEC_SKIP && dest == DEST_WORK) |=>
      work_reg == $past(file_rdata) - ONE_BYTE && !file_we)
    else $error("decrement skip to work wrong");
  a_zero_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !exec |=> $stable(zero_flag) && $stable(work_reg))
    else $error("state moved without an executed op");
endmodule

// ==== logic/fr_unary_pkg.sv ====
// constants and types shared by the file-register unary datapath
package fr_unary_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int OP_W = 3;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // opcode encoding presented by the decoder
  localparam logic [OP_W-1:0] OP_INVERT = 3'h0;
  localparam logic [OP_W-1:0] OP_ZERO_FILE = 3'h1;
  localparam logic [OP_W-1:0] OP_ZERO_WORK = 3'h2;
  localparam logic [OP_W-1:0] OP_DEC = 3'h3;
  localparam logic [OP_W-1:0] OP_DEC_SKIP = 3'h4;
  localparam logic [OP_W-1:0] OP_INC_SKIP = 3'h5;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SKIP = 2'b10
  } seq_state_t;
endpackage

// ==== logic/fr_unary_calc.sv ====
// combinational result, zero and skip computation for one opcode
`timescale 1ns/1ps
module fr_unary_calc
  import fr_unary_pkg::*;
(
  input wire logic [OP_W-1:0] op,
  input wire logic [DATA_W-1:0] operand,
  output logic [DATA_W-1:0] result,
  output logic zero,
  output logic flag_we,
  output logic skip,
  output logic legal
);
  always_comb begin
    result = ZERO_BYTE;
    flag_we = 1'b0;
    skip = 1'b0;
    legal = 1'b1;
    case (op)
      OP_INVERT: begin
        result = ~operand;
        flag_we = 1'b1;
      end
      OP_ZERO_FILE: begin
        result = ZERO_BYTE;
        flag_we = 1'b1;
      end
      OP_ZERO_WORK: begin
        result = ZERO_BYTE;
        flag_we = 1'b1;
      end
      OP_DEC: begin
        result = operand - ONE_BYTE;
        flag_we = 1'b1;
      end
      OP_DEC_SKIP: begin
        result = operand - ONE_BYTE;
        skip = (result == ZERO_BYTE);
      end
      // increment wraps modulo 256, flags untouched
      OP_INC_SKIP: begin
        result = operand + ONE_BYTE;
        skip = (result == ZERO_BYTE);
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    zero = (result == ZERO_BYTE);
  end
endmodule

// ==== dv/tb_fr_unary_alu.sv ====
// self-checking testbench for the file-register unary datapath
`timescale 1ns/1ps
module tb_fr_unary_alu;
  import fr_unary_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic issue = 1'b0;
  logic [OP_W-1:0] op = OP_INVERT;
  logic dest = DEST_WORK;
  logic [ADDR_W-1:0] file_addr = ADDR_RESET;
  logic [DATA_W-1:0] file_rdata = ZERO_BYTE;
  logic file_we, zero_flag, idle_slot, busy_skip;
  logic [ADDR_W-1:0] file_waddr;
  logic [DATA_W-1:0] file_wdata, work_reg;
  int n_fail = 0;
  int checks_done = 0;
  logic [DATA_W-1:0] w_exp = W_RESET;
  logic z_exp = 1'b0;

  always #25 clock = ~clock;

  fr_unary_alu u_dut (.clock(clock), .rst_n(rst_n), .issue(issue), .op(op), .dest(dest),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .work_reg(work_reg),
    .zero_flag(zero_flag), .idle_slot(idle_slot), .busy_skip(busy_skip));

  // ****************************************
  // compare and drive helpers
  // ****************************************
  task cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // issues back to back: the next call drives at the same falling edge
  task op_chk(input logic [2:0] o, input logic d, input logic [6:0] a,
              input logic [7:0] rd, input logic [7:0] res);
    logic to_file;
    logic skip;
    to_file = (o == OP_ZERO_FILE) || (d == DEST_FILE && o != OP_ZERO_WORK);
    skip = (o == OP_DEC_SKIP || o == OP_INC_SKIP) && res == ZERO_BYTE;
    if (!to_file) w_exp = res;
    if (o < OP_DEC_SKIP) z_exp = (res == ZERO_BYTE);
    issue = 1'b1;
    op = o;
    dest = d;
    file_addr = a;
    file_rdata = rd;
    @(negedge clock);
    cmp_bit("file_we", to_file, file_we);
    if (to_file) begin
      cmp_byte("file_waddr", {1'b0, a}, {1'b0, file_waddr});
      cmp_byte("file_wdata", res, file_wdata);
    end
    cmp_byte("work_reg", w_exp, work_reg);
    cmp_bit("zero_flag", z_exp, zero_flag);
    cmp_bit("idle_slot", skip, idle_slot);
    cmp_bit("busy_skip", skip, busy_skip);
  endtask

  // an issue that must leave every result untouched
  task refuse(input logic [2:0] o);
    issue = 1'b1;
    op = o;
    dest = DEST_WORK;
    file_rdata = 8'h3c;
    @(negedge clock);
    cmp_bit("file_we", 1'b0, file_we);
    cmp_byte("work_reg", w_exp, work_reg);
    cmp_bit("zero_flag", z_exp, zero_flag);
    cmp_bit("idle_slot", 1'b0, idle_slot);
    cmp_bit("busy_skip", 1'b0, busy_skip);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_invert();
    op_chk(OP_INVERT, DEST_WORK, 7'h05, 8'ha5, 8'h5a);
    op_chk(OP_INVERT, DEST_FILE, 7'h7f, 8'hff, 8'h00);
  endtask

  task t_clear();
    op_chk(OP_INVERT, DEST_WORK, 7'h01, 8'h0f, 8'hf0);
    op_chk(OP_ZERO_FILE, DEST_WORK, 7'h7f, 8'h77, 8'h00);
    op_chk(OP_INVERT, DEST_FILE, 7'h00, 8'h00, 8'hff);
    op_chk(OP_ZERO_WORK, DEST_FILE, 7'h12, 8'h44, 8'h00);
    refuse(3'h6);
    refuse(3'h7);
  endtask

  task t_dec();
    op_chk(OP_DEC, DEST_WORK, 7'h20, 8'h01, 8'h00);
    op_chk(OP_DEC, DEST_FILE, 7'h21, 8'h00, 8'hff);
    op_chk(OP_DEC, DEST_WORK, 7'h22, 8'h80, 8'h7f);
  endtask

  task t_dec_skip();
    op_chk(OP_DEC_SKIP, DEST_WORK, 7'h30, 8'h02, 8'h01);
    op_chk(OP_DEC_SKIP, DEST_FILE, 7'h31, 8'h01, 8'h00);
    refuse(OP_ZERO_WORK);
    op_chk(OP_DEC_SKIP, DEST_WORK, 7'h32, 8'h00, 8'hff);
  endtask

  task t_inc_skip();
    op_chk(OP_ZERO_WORK, DEST_WORK, 7'h00, 8'h00, 8'h00);
    op_chk(OP_INC_SKIP, DEST_WORK, 7'h40, 8'hff, 8'h00);
    refuse(OP_INVERT);
    op_chk(OP_INC_SKIP, DEST_FILE, 7'h41, 8'h7f, 8'h80);
    op_chk(OP_INC_SKIP, DEST_FILE, 7'h42, 8'hff, 8'h00);
    refuse(OP_DEC);
  endtask

  task finish_test();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(negedge clock);
    cmp_byte("work_reg", W_RESET, work_reg);
    cmp_bit("zero_flag", 1'b0, zero_flag);
    cmp_bit("file_we", 1'b0, file_we);
    rst_n = 1'b1;
    @(negedge clock);
    t_invert();
    t_clear();
    t_dec();
    t_dec_skip();
    t_inc_skip();
    issue = 1'b0;
    @(negedge clock);
    finish_test();
  end

  // the whole sequence needs about 35 cycles, so 400 means a hang
  initial begin
    #(50 * 400);
    n_fail++;
    finish_test();
  end
endmodule
